// ===== hw/color_seq_pkg.sv
package color_seq_pkg;
  localparam logic [4:0] OFS_ENABLE = 5'h00;
  localparam logic [4:0] OFS_INTEGRATION_TIME_SETTING = 5'h01;
  localparam logic [4:0] OFS_WAIT_TIME_SETTING = 5'h03;
  localparam logic [4:0] OFS_LTH_LO = 5'h04;
  localparam logic [4:0] OFS_LTH_HI = 5'h05;
  localparam logic [4:0] OFS_HTH_LO = 5'h06;
  localparam logic [4:0] OFS_HTH_HI = 5'h07;
  localparam logic [4:0] OFS_PERS = 5'h0c;
  localparam logic [4:0] OFS_CONFIG = 5'h0d;
  localparam logic [4:0] OFS_CONTROL = 5'h0f;
  localparam logic [4:0] OFS_ID = 5'h12;
  localparam logic [4:0] OFS_STATUS = 5'h13;
  localparam logic [4:0] OFS_DATA = 5'h14;
  localparam logic [4:0] OFS_DATA_LAST = 5'h1b;
  localparam int EN_PON = 0;
  localparam int EN_CONV = 1;
  localparam int EN_WAIT = 3;
  localparam int EN_INT_OUT = 4;
  localparam int CFG_LONG_WAIT = 1;
  localparam int ST_VALID = 0;
  localparam int ST_INT = 4;
  localparam int CMD_SEL = 7;
  localparam logic [1:0] CMD_TYPE_AUTO = 2'h1;
  localparam logic [1:0] CMD_TYPE_SF = 2'h3;
  localparam logic [4:0] SF_INT_CLEAR = 5'h06;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TIME = 8'hff;
  localparam int TIME_FULL = 256;
  localparam int LONG_WAIT_MULT = 12;
  localparam int STEP_TIME_US = 2400;
  localparam int CLK_FREQ_MHZ = 200;
  localparam int STEP_CYCLES = STEP_TIME_US * CLK_FREQ_MHZ;
  typedef enum logic [2:0] {
    SEQ_SLEEP = 3'b000, SEQ_IDLE = 3'b001, SEQ_WARM = 3'b010, SEQ_WAIT = 3'b011,
    SEQ_INIT = 3'b100, SEQ_ADC = 3'b101, SEQ_COPY = 3'b110
  } seq_state_e;
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000, I2C_RX = 3'b001, I2C_ACK = 3'b010, I2C_TX = 3'b011,
    I2C_TXACK = 3'b100
  } i2c_state_e;
endpackage : color_seq_pkg

// ===== hw/host_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface host_link_if;
  logic start;
  logic busy;
  logic wr;
  logic first;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport target (output start, output busy, output wr, output first, output rd,
                  output wdata, input rdata);
  modport core (input start, input busy, input wr, input first, input rd,
                input wdata, output rdata);
endinterface : host_link_if
`default_nettype wire

// ===== hw/data_store.sv
`timescale 1ns/1ps
`default_nettype none
module data_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [DEPTH*WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  // whole-set write keeps every byte of one result together
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) mem_q[i] <= '0;
      else if (we_i) mem_q[i] <= wdata_i[i*WIDTH +: WIDTH];
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_o <= '0;
    else rdata_o <= mem_q[raddr_i];
  end
endmodule : data_store
`default_nettype wire

// ===== hw/i2c_target.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_target import color_seq_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h30 // arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  host_link_if.target lk
);
  logic [2:0] scl_s_q, sda_s_q;
  logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  i2c_state_e st_q;
  logic [7:0] sh_q, wdata_q;
  logic [3:0] cnt_q;
  logic rw_q, addr_ph_q, first_q, fst_q, start_q, wr_q, rd_q;
  // a pin change counts once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end
  wire rise = scl_f_q & ~scl_p_q;
  wire fall = ~scl_f_q & scl_p_q;
  wire start_c = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  wire stop_c = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
  wire addr_hit = sh_q[7:1] == DEV_ADDR;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= I2C_IDLE;
      sh_q <= '0;
      wdata_q <= '0;
      cnt_q <= '0;
      {rw_q, addr_ph_q, first_q, fst_q, start_q, wr_q, rd_q, sda_oe_o} <= '0;
    end else begin
      start_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      if (start_c) begin
        st_q <= I2C_RX;
        cnt_q <= '0;
        addr_ph_q <= 1'b1;
        sda_oe_o <= 1'b0;
        start_q <= 1'b1;
      end else if (stop_c) begin
        st_q <= I2C_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_q)
          I2C_RX: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], sda_f_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && cnt_q == 4'h8) begin
              cnt_q <= '0;
              if (addr_ph_q) begin
                addr_ph_q <= 1'b0;
                first_q <= 1'b1;
                rw_q <= sh_q[0];
                st_q <= addr_hit ? I2C_ACK : I2C_IDLE;
                sda_oe_o <= addr_hit;
              end else begin
                wr_q <= 1'b1;
                wdata_q <= sh_q;
                fst_q <= first_q;
                first_q <= 1'b0;
                st_q <= I2C_ACK;
                sda_oe_o <= 1'b1;
              end
            end
          end
          I2C_ACK: begin
            if (fall && rw_q) begin
              sh_q <= lk.rdata;
              sda_oe_o <= ~lk.rdata[7];
              rd_q <= 1'b1;
              cnt_q <= 4'h1;
              st_q <= I2C_TX;
            end else if (fall) begin
              sda_oe_o <= 1'b0;
              st_q <= I2C_RX;
            end
          end
          I2C_TX: begin
            if (fall && cnt_q == 4'h8) begin
              sda_oe_o <= 1'b0;
              st_q <= I2C_TXACK;
            end else if (fall) begin
              sda_oe_o <= ~sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
          I2C_TXACK: begin
            if (rise) st_q <= sda_f_q ? I2C_IDLE : I2C_ACK;
          end
          default: st_q <= I2C_IDLE;
        endcase
      end
    end
  end
  assign lk.start = start_q;
  assign lk.busy = st_q != I2C_IDLE;
  assign lk.wr = wr_q;
  assign lk.first = fst_q;
  assign lk.rd = rd_q;
  assign lk.wdata = wdata_q;
endmodule : i2c_target
`default_nettype wire

// ===== hw/color_sensor_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module color_sensor_sequencer import color_seq_pkg::*; #(
  parameter int STEP_CYC = STEP_CYCLES,
  parameter int PRESC_W = 20,
  parameter logic [7:0] ID_VALUE = 8'h5a // arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic int_oe_o,
  output logic adc_integrate_o,
  output logic [1:0] adc_gain_o,
  output logic [2:0] state_o,
  input wire logic [15:0] clear_count_i,
  input wire logic [15:0] red_count_i,
  input wire logic [15:0] green_count_i,
  input wire logic [15:0] blue_count_i
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  host_link_if lk ();
  seq_state_e state_q, state_d;
  logic [7:0] enable_q, integration_time_setting_q, wait_time_setting_q, pers_q, config_q, control_q;
  logic [15:0] lth_q, hth_q;
  logic [4:0] ptr_q;
  logic autoinc_q, int_q, valid_q, warm_q;
  logic [PRESC_W-1:0] presc_q;
  logic [11:0] step_q;
  logic [5:0] pcnt_q;
  logic [63:0] pend_q;
  logic [7:0] store_rdata, reg_rdata;

  // release of the asynchronous reset is retimed; everything else uses rst_n
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  i2c_target u_i2c (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .lk(lk.target)
  );

  // command byte and register write decode
  wire wr_cmd = lk.wr & lk.first & lk.wdata[CMD_SEL];
  wire sf_cmd = wr_cmd & (lk.wdata[6:5] == CMD_TYPE_SF);
  wire sf_clear = sf_cmd & (lk.wdata[4:0] == SF_INT_CLEAR);
  wire set_ptr = wr_cmd & ~sf_cmd;
  wire wr_reg = lk.wr & ~lk.first;
  wire ptr_inc = (wr_reg | lk.rd) & autoinc_q;
  wire hit_enable = wr_reg & (ptr_q == OFS_ENABLE);
  wire hit_integration_time_setting = wr_reg & (ptr_q == OFS_INTEGRATION_TIME_SETTING);
  wire hit_wait_time_setting = wr_reg & (ptr_q == OFS_WAIT_TIME_SETTING);
  wire hit_lth_lo = wr_reg & (ptr_q == OFS_LTH_LO);
  wire hit_lth_hi = wr_reg & (ptr_q == OFS_LTH_HI);
  wire hit_hth_lo = wr_reg & (ptr_q == OFS_HTH_LO);
  wire hit_hth_hi = wr_reg & (ptr_q == OFS_HTH_HI);
  wire hit_pers = wr_reg & (ptr_q == OFS_PERS);
  wire hit_config = wr_reg & (ptr_q == OFS_CONFIG);
  wire hit_control = wr_reg & (ptr_q == OFS_CONTROL);

  wire power_on_bit = enable_q[EN_PON];
  wire conv = enable_q[EN_CONV];
  wire wen = enable_q[EN_WAIT];
  wire interrupt_output_enable = enable_q[EN_INT_OUT];

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= '0;
      autoinc_q <= 1'b0;
    end else if (set_ptr) begin
      ptr_q <= lk.wdata[4:0];
      autoinc_q <= lk.wdata[6:5] == CMD_TYPE_AUTO;
    end else if (ptr_inc) begin
      ptr_q <= ptr_q + 5'h01;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= RST_ZERO;
      integration_time_setting_q <= RST_TIME;
      wait_time_setting_q <= RST_TIME;
      lth_q <= {RST_ZERO, RST_ZERO};
      hth_q <= {RST_ZERO, RST_ZERO};
      pers_q <= RST_ZERO;
      config_q <= RST_ZERO;
      control_q <= RST_ZERO;
    end else begin
      if (hit_enable) enable_q <= lk.wdata;
      if (hit_integration_time_setting) integration_time_setting_q <= lk.wdata;
      if (hit_wait_time_setting) wait_time_setting_q <= lk.wdata;
      if (hit_lth_lo) lth_q[7:0] <= lk.wdata;
      if (hit_lth_hi) lth_q[15:8] <= lk.wdata;
      if (hit_hth_lo) hth_q[7:0] <= lk.wdata;
      if (hit_hth_hi) hth_q[15:8] <= lk.wdata;
      if (hit_pers) pers_q <= lk.wdata;
      if (hit_config) config_q <= lk.wdata;
      if (hit_control) control_q <= lk.wdata;
    end
  end

  // read selection; data bytes come from the buffered copy only
  wire data_sel = (ptr_q >= OFS_DATA) && (ptr_q <= OFS_DATA_LAST);
  wire [7:0] status_val = 8'((int_q << ST_INT) | (valid_q << ST_VALID));
  assign reg_rdata =
    (ptr_q == OFS_ENABLE) ? enable_q :
    (ptr_q == OFS_INTEGRATION_TIME_SETTING) ? integration_time_setting_q :
    (ptr_q == OFS_WAIT_TIME_SETTING) ? wait_time_setting_q :
    (ptr_q == OFS_LTH_LO) ? lth_q[7:0] :
    (ptr_q == OFS_LTH_HI) ? lth_q[15:8] :
    (ptr_q == OFS_HTH_LO) ? hth_q[7:0] :
    (ptr_q == OFS_HTH_HI) ? hth_q[15:8] :
    (ptr_q == OFS_PERS) ? pers_q :
    (ptr_q == OFS_CONFIG) ? config_q :
    (ptr_q == OFS_CONTROL) ? control_q :
    (ptr_q == OFS_ID) ? ID_VALUE :
    (ptr_q == OFS_STATUS) ? status_val : 8'h00;
  assign lk.rdata = data_sel ? store_rdata : reg_rdata;

  // step timing: one step is STEP_CYC cycles
  wire [8:0] adc_steps = 9'(TIME_FULL - int'(integration_time_setting_q));
  wire [8:0] wait_base = 9'(TIME_FULL - int'(wait_time_setting_q));
  wire [11:0] wait_steps = config_q[CFG_LONG_WAIT] ?
    12'(int'(wait_base) * LONG_WAIT_MULT) : {3'h0, wait_base};
  wire [11:0] step_target =
    (state_q == SEQ_WAIT) ? wait_steps :
    (state_q == SEQ_ADC) ? {3'h0, adc_steps} : 12'h001;
  wire step_tick = presc_q == PRESC_W'(STEP_CYC - 1);
  wire phase_done = step_tick & (step_q == step_target - 12'h001);
  wire timed = (state_q == SEQ_WARM) | (state_q == SEQ_WAIT) |
               (state_q == SEQ_INIT) | (state_q == SEQ_ADC);

  always_comb begin
    state_d = state_q;
    case (state_q)
      SEQ_SLEEP: if (lk.start) state_d = SEQ_IDLE;
      SEQ_IDLE: begin
        if (!power_on_bit) state_d = SEQ_SLEEP;
        else if (!warm_q) state_d = SEQ_WARM;
        else if (conv) state_d = wen ? SEQ_WAIT : SEQ_INIT;
      end
      SEQ_WARM: begin
        if (!power_on_bit) state_d = SEQ_SLEEP;
        else if (phase_done) state_d = SEQ_IDLE;
      end
      SEQ_WAIT: begin
        if (!power_on_bit) state_d = SEQ_SLEEP;
        else if (phase_done) state_d = SEQ_INIT;
      end
      SEQ_INIT: begin
        if (!power_on_bit) state_d = SEQ_SLEEP;
        else if (phase_done) state_d = SEQ_ADC;
      end
      SEQ_ADC: begin
        if (!power_on_bit) state_d = SEQ_SLEEP;
        else if (phase_done) state_d = SEQ_COPY;
      end
      // copy waits for the bus to go quiet so a read never mixes two results
      SEQ_COPY: if (!lk.busy) state_d = SEQ_IDLE;
      default: state_d = SEQ_SLEEP;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) state_q <= SEQ_SLEEP;
    else state_q <= state_d;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
      step_q <= '0;
    end else if (!timed || state_d != state_q) begin
      presc_q <= '0;
      step_q <= '0;
    end else if (step_tick) begin
      presc_q <= '0;
      step_q <= step_q + 12'h001;
    end else begin
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) warm_q <= 1'b0;
    else if (!power_on_bit) warm_q <= 1'b0;
    else if (state_q == SEQ_WARM && phase_done) warm_q <= 1'b1;
  end

  // result capture, thresholds and persistence
  wire adc_end = (state_q == SEQ_ADC) & (state_d == SEQ_COPY);
  wire store_we = (state_q == SEQ_COPY) & ~lk.busy;
  wire below = clear_count_i < lth_q;
  wire above = (lth_q <= hth_q) && (clear_count_i > hth_q);
  wire out_range = below | above;

  function automatic logic [5:0] pers_limit(input logic [3:0] f);
    if (f < 4'h4) pers_limit = {2'b00, f};
    else pers_limit = 6'(5 * (int'(f) - 3));
  endfunction : pers_limit

  wire [5:0] limit = pers_limit(pers_q[3:0]);
  wire [5:0] pcnt_next = (pcnt_q == 6'h3f) ? pcnt_q : pcnt_q + 6'h01;
  wire fire = adc_end & ((limit == 6'h00) | (out_range & (pcnt_next >= limit)));

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
      pcnt_q <= '0;
    end else if (adc_end) begin
      pend_q <= {blue_count_i, green_count_i, red_count_i, clear_count_i};
      pcnt_q <= out_range ? pcnt_next : 6'h00;
    end
  end

  data_store #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_store (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .we_i(store_we),
    .wdata_i(pend_q),
    .raddr_i(3'(ptr_q - OFS_DATA)),
    .rdata_o(store_rdata)
  );

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      int_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      // a new event in the clear cycle wins
      if (fire) int_q <= 1'b1;
      else if (sf_clear) int_q <= 1'b0;
      if (!conv || !power_on_bit) valid_q <= 1'b0;
      else if (store_we) valid_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      int_oe_o <= 1'b0;
      adc_integrate_o <= 1'b0;
      adc_gain_o <= 2'b00;
      sda_o <= 1'b0;
    end else begin
      int_oe_o <= int_q & interrupt_output_enable;
      adc_integrate_o <= state_d == SEQ_ADC;
      adc_gain_o <= control_q[1:0];
      sda_o <= 1'b0;
    end
  end
  assign state_o = state_q;

  // checks
  logic [31:0] cyc_q;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) cyc_q <= '0;
    else if (state_d != state_q) cyc_q <= '0;
    else cyc_q <= cyc_q + 32'h1;
  end
  wire [31:0] step32 = 32'(STEP_CYC);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  a_sleep_wake: assert property (
    state_q == SEQ_SLEEP && lk.start |=> state_q == SEQ_IDLE)
    else $error("start did not wake the sequencer");
  a_idle_no_power: assert property (
    state_q == SEQ_IDLE && !power_on_bit |=> state_q == SEQ_SLEEP)
    else $error("idle without power-on did not sleep");
  a_warm_time: assert property (
    state_q == SEQ_WARM && state_d == SEQ_IDLE |-> cyc_q == step32 - 32'h1)
    else $error("warm-up length wrong");
  a_init_time: assert property (
    state_q == SEQ_INIT && state_d == SEQ_ADC |-> cyc_q == step32 - 32'h1)
    else $error("init length wrong");
  a_adc_time: assert property (
    adc_end |-> cyc_q == 32'(adc_steps) * step32 - 32'h1)
    else $error("conversion length wrong");
  a_wait_time: assert property (
    state_q == SEQ_WAIT && state_d == SEQ_INIT |->
      cyc_q == 32'(wait_steps) * step32 - 32'h1)
    else $error("wait length wrong");
  a_int_hold: assert property (
    int_q && !sf_clear |=> int_q)
    else $error("interrupt dropped without clear command");
  a_int_at_end: assert property (
    $rose(int_q) |-> $past(adc_end))
    else $error("interrupt rose outside conversion end");
  a_int_pin: assert property (
    !interrupt_output_enable |=> !int_oe_o ##1 !int_oe_o || interrupt_output_enable)
    else $error("interrupt pin driven while output disabled");
  a_pers_reset: assert property (
    adc_end && !out_range |=> pcnt_q == 6'h00)
    else $error("persistence counter not cleared");
  a_copy_advance: assert property (
    store_we |=> state_q == SEQ_IDLE)
    else $error("sequencer did not advance after copy");

  c_full_cycle: cover property (state_q == SEQ_WAIT ##[1:1000] adc_end ##[1:1000] store_we);
  c_int_fire: cover property (fire && out_range && limit > 6'h01);
  c_sf_clear: cover property (int_q && sf_clear);
  c_restart: cover property (store_we ##1 state_q == SEQ_IDLE ##1 state_q == SEQ_WAIT);
  c_inverted_window: cover property (adc_end && lth_q > hth_q);
endmodule : color_sensor_sequencer
`default_nettype wire

// ===== tb/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter int HALF = 2,
  parameter logic [6:0] ADDR = 7'h30 // arbitrary value
) (
  input wire logic link_clk_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_drv_o
);
  int nacks = 0;
  logic [7:0] rbuf [16];
  initial begin
    scl_o = 1'b1;
    sda_drv_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk_i);
  endtask : tick
  // sda moves only while scl is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_drv_o = ~b;
    tick(HALF);
    scl_o = 1'b1;
    tick(HALF);
    r = sda_line_i;
    scl_o = 1'b0;
    tick(1);
  endtask : bit_io
  task automatic start();
    sda_drv_o = 1'b0;
    tick(1);
    scl_o = 1'b1;
    tick(HALF);
    sda_drv_o = 1'b1;
    tick(HALF);
    scl_o = 1'b0;
    tick(1);
  endtask : start
  // scl stands high after stop until the next frame
  task automatic stop();
    sda_drv_o = 1'b1;
    tick(1);
    scl_o = 1'b1;
    tick(HALF);
    sda_drv_o = 1'b0;
    tick(HALF);
  endtask : stop
  task automatic put(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nacks++;
  endtask : put
  task automatic xfer(input logic [7:0] cmd, input int nw, input logic [31:0] wd, input int nr);
    logic r;
    start();
    put({ADDR, 1'b0});
    put(cmd);
    for (int i = 0; i < nw; i++) put(wd[8*i +: 8]);
    if (nr > 0) begin
      start();
      put({ADDR, 1'b1});
      for (int k = 0; k < nr; k++) begin
        for (int i = 7; i >= 0; i--) begin
          bit_io(1'b1, r);
          rbuf[k][i] = r;
        end
        bit_io(k == nr - 1, r);
      end
    end
    stop();
  endtask : xfer
  // special-function command byte: select, type 11, code 0x06
  task automatic clear_int();
    xfer(8'he6, 0, 32'h0, 0);
  endtask : clear_int
endmodule : i2c_host_model
`default_nettype wire

// ===== tb/tb_color_sensor_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_color_sensor_sequencer;
  import color_seq_pkg::*;
  logic clk_sys_i = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] cnt [4];
  logic [7:0] exp_rst [4] = '{8'h00, 8'hff, 8'h00, 8'hff};
  logic scl, sda_drv, sda_oe, int_oe, adc_int;
  logic sda_out;
  logic [1:0] adc_gain;
  logic [2:0] state_o;
  wire logic sda_line;
  int err_count = 0;
  int comparisons = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  initial begin
    #1.3;
    forever #80 link_clk = ~link_clk;
  end
  // open-drain line with pull-up
  assign sda_line = ~(sda_drv | sda_oe);
  color_sensor_sequencer #(.STEP_CYC(20), .PRESC_W(8)) color_sensor_sequencer_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .int_oe_o(int_oe), .adc_integrate_o(adc_int),
    .adc_gain_o(adc_gain),
    .state_o(state_o), .clear_count_i(cnt[0]), .red_count_i(cnt[1]),
    .green_count_i(cnt[2]), .blue_count_i(cnt[3]));
  i2c_host_model #(.HALF(1)) i2c_host_model_i (.link_clk_i(link_clk), .sda_line_i(sda_line),
    .scl_o(scl), .sda_drv_o(sda_drv));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic wait_for(input logic [2:0] st, input bit same);
    int n;
    n = 0;
    while ((state_o === st) == same && n < 30000) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 30000) begin
      err_count++;
      conclude();
    end
  endtask : wait_for
  // fresh skips a state already under way, whose count would come out short
  task automatic dur(input logic [2:0] st, input int exp, input bit fresh);
    int n;
    if (fresh) wait_for(st, 1'b1);
    wait_for(st, 1'b0);
    n = 0;
    while (state_o === st && n < 1000) begin
      @(negedge clk_sys_i);
      n++;
    end
    check(16'(n), 16'(exp));
  endtask : dur
  task automatic adc_end();
    wait_for(SEQ_ADC, 1'b0);
    check(int_oe, 1'b0);
    @(negedge clk_sys_i);
    check(adc_int, 1'b1);
    wait_for(SEQ_ADC, 1'b1);
    repeat (2) @(negedge clk_sys_i);
  endtask : adc_end
  task automatic wr(input logic [4:0] a, input int nw, input logic [31:0] d);
    i2c_host_model_i.xfer({3'h5, a}, nw, d, 0);
  endtask : wr
  task automatic rd(input logic [4:0] a, input int nr);
    i2c_host_model_i.xfer({3'h5, a}, 0, 32'h0, nr);
  endtask : rd
  initial begin
    cnt = '{16'h0100, 16'h1234, 16'h5678, 16'h9abc};
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    check(state_o, SEQ_SLEEP);
    rd(OFS_ENABLE, 4);
    foreach (exp_rst[i]) check(i2c_host_model_i.rbuf[i], exp_rst[i]);
    check(state_o, SEQ_SLEEP);
    wr(OFS_LTH_LO, 4, 32'h4000_0800);
    // middle byte lands on an unmapped place and must not disturb its neighbours
    wr(OFS_INTEGRATION_TIME_SETTING, 3, 32'h00fd_55fe);
    wr(OFS_ENABLE, 1, 32'h1b);
    check(state_o, SEQ_SLEEP);
    fork
      rd(OFS_STATUS, 1);
      dur(SEQ_WARM, 20, 1'b0);
    join
    dur(SEQ_WAIT, 60, 1'b1);
    dur(SEQ_INIT, 20, 1'b0);
    dur(SEQ_ADC, 40, 1'b0);
    dur(SEQ_WAIT, 60, 1'b0);
    check(int_oe, 1'b1);
    rd(OFS_STATUS, 9);
    check(i2c_host_model_i.rbuf[0], 8'h11);
    for (int i = 0; i < 8; i++) check(i2c_host_model_i.rbuf[i+1], cnt[i/2][8*(i%2) +: 8]);
    @(negedge clk_sys_i);
    cnt[0] = 16'h2000;
    // filter goes in first, so no unfiltered event lands after the clear
    wr(OFS_PERS, 1, 32'h03);
    i2c_host_model_i.clear_int();
    check(int_oe, 1'b0);
    adc_end();
    // an in-range result in the middle must restart the run of three
    for (int k = 1; k <= 6; k++) begin
      cnt[0] = (k == 3) ? 16'h2000 : 16'h0100;
      adc_end();
      check(int_oe, 16'(k == 6));
    end
    wr(OFS_LTH_LO, 4, 32'h2000_3000);
    @(negedge clk_sys_i);
    cnt[0] = 16'h5000;
    i2c_host_model_i.clear_int();
    for (int k = 0; k < 4; k++) adc_end();
    check(int_oe, 1'b0);
    wr(OFS_CONFIG, 1, 32'h02);
    dur(SEQ_WAIT, 720, 1'b1);
    // fixed-address command: both bytes land on the control register
    i2c_host_model_i.xfer({3'h4, OFS_CONTROL}, 2, 32'h0301, 0);
    check(adc_gain, 2'h3);
    check(sda_out, 1'b0);
    wr(OFS_ENABLE, 1, 32'h00);
    wait_for(SEQ_SLEEP, 1'b0);
    check(state_o, SEQ_SLEEP);
    check(16'(i2c_host_model_i.nacks), 16'h0000);
    conclude();
  end
endmodule : tb_color_sensor_sequencer
`default_nettype wire
